/* File: logic/asp_pkg.sv */
package asp_pkg;

	// ----------------------------------------
	// bit rates and clock
	// ----------------------------------------
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int          RATE_W         = 4;
	localparam int          NUM_RATES      = 12;
	localparam int          DIV_W          = 16;
	localparam int          BAUD_LIST [NUM_RATES] = '{
		9600, 19200, 38400, 57600, 115200, 230400,
		460800, 921600, 3000000, 3250000, 6000000, 6500000};
	localparam logic [RATE_W-1:0] RATE_DEFAULT = 4'h4;

	// ----------------------------------------
	// character formats
	// ----------------------------------------
	typedef enum logic [2:0] {
		ASP_FMT_8N2,
		ASP_FMT_8N1,
		ASP_FMT_8E1,
		ASP_FMT_8O1,
		ASP_FMT_7E1,
		ASP_FMT_7O1
	} asp_fmt_e;
	localparam asp_fmt_e FMT_DEFAULT = ASP_FMT_8N1;

	// ----------------------------------------
	// flow control and in-band characters
	// ----------------------------------------
	localparam logic      FLOW_NONE   = 1'b0;
	localparam logic      FLOW_SW     = 1'b1;
	localparam logic [7:0] CHAR_XON   = 8'h11;
	localparam logic [7:0] CHAR_XOFF  = 8'h13;
	localparam logic [7:0] CHAR_AUTO  = 8'h41;

	// ----------------------------------------
	// line levels
	// ----------------------------------------
	localparam logic LINE_IDLE  = 1'b1;
	localparam logic LINE_START = 1'b0;
	localparam logic LINE_STOP  = 1'b1;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [DIV_W-1:0] asp_div(input logic [RATE_W-1:0] r);
		int d;
		d = 1;
		for (int i = 0; i < NUM_RATES; i++) begin
			if (r == RATE_W'(i)) begin
				d = int'(CLK_HZ / BAUD_LIST[i]);
			end
		end
		return DIV_W'(d);
	endfunction : asp_div

	function automatic logic [3:0] asp_data_bits(input asp_fmt_e f);
		return (f == ASP_FMT_7E1 || f == ASP_FMT_7O1) ? 4'h7 : 4'h8;
	endfunction : asp_data_bits

	function automatic logic asp_has_par(input asp_fmt_e f);
		return f inside {ASP_FMT_8E1, ASP_FMT_8O1, ASP_FMT_7E1, ASP_FMT_7O1};
	endfunction : asp_has_par

	function automatic logic asp_odd(input asp_fmt_e f);
		return (f == ASP_FMT_8O1 || f == ASP_FMT_7O1);
	endfunction : asp_odd

endpackage : asp_pkg

/* File: logic/asp_tx.sv */
`timescale 1ns/1ps
module asp_tx
	import asp_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 arst_n_i,
	input  wire logic                 ce_i,
	// configuration
	input  wire logic [DIV_W-1:0]     div_i,
	input  asp_fmt_e                  fmt_i,
	input  wire logic                 en_i,
	// character in
	input  wire logic                 valid_i,
	input  wire logic [7:0]           data_i,
	output logic                      ready_o,
	// line
	output logic                      txd_o
);

	// frame shifts out lsb first: start, data, parity, stop(s)
	logic [11:0]      sh_q;
	logic [3:0]       left_q;
	logic [DIV_W-1:0] cnt_q;
	logic             busy_q;
	logic [11:0]      frame;
	logic [3:0]       nbits;
	logic             par;
	logic [7:0]       dmask;

	assign dmask   = (asp_data_bits(fmt_i) == 4'h7) ? {1'b0, data_i[6:0]} : data_i;
	assign par     = ^dmask ^ asp_odd(fmt_i);
	assign nbits   = 4'h1 + asp_data_bits(fmt_i) + {3'h0, asp_has_par(fmt_i)}
		+ ((fmt_i == ASP_FMT_8N2) ? 4'h2 : 4'h1);
	assign frame   = (asp_data_bits(fmt_i) == 4'h7)
		? {2'h3, LINE_STOP, par, dmask[6:0], LINE_START}
		: (asp_has_par(fmt_i) ? {1'b1, LINE_STOP, par, dmask, LINE_START}
		                      : {1'b1, LINE_STOP, LINE_STOP, dmask, LINE_START});
	assign ready_o = en_i && !busy_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sh_q   <= '1;
			left_q <= '0;
			cnt_q  <= '0;
			busy_q <= 1'b0;
			txd_o  <= LINE_IDLE;
		end else if (ce_i) begin
			if (!busy_q) begin
				txd_o <= LINE_IDLE;
				if (valid_i && en_i) begin
					sh_q   <= frame;
					left_q <= nbits;
					cnt_q  <= '0;
					busy_q <= 1'b1;
				end
			end else if (cnt_q == '0) begin
				txd_o  <= sh_q[0];
				sh_q   <= {1'b1, sh_q[11:1]};
				cnt_q  <= div_i - DIV_W'(1);
				left_q <= left_q - 4'h1;
				if (left_q == 4'h0) begin
					busy_q <= 1'b0;
					txd_o  <= LINE_IDLE;
				end
			end else begin
				cnt_q <= cnt_q - DIV_W'(1);
			end
		end
	end

endmodule : asp_tx

/* File: logic/asp_top.sv */
`timescale 1ns/1ps
module asp_top
	import asp_pkg::*;
(
	// clock and reset
	input  wire logic                 CLK_I,
	input  wire logic                 ARST_N_I,
	input  wire logic                 CE_I,
	// commands
	input  wire logic                 PIN_FUNC_SEL_I,
	input  wire logic                 AUTO_EN_I,
	input  wire logic                 BIT_RATE_CMD_I,
	input  wire logic [RATE_W-1:0]    BIT_RATE_I,
	input  wire logic                 CHAR_FMT_CMD_I,
	input  asp_pkg::asp_fmt_e         CHAR_FMT_I,
	input  wire logic                 FLOW_CTRL_CMD_I,
	input  wire logic                 FLOW_CTRL_I,
	// shared bus pins
	input  wire logic                 SCL_I,
	output logic                      SCL_O,
	output logic                      SCL_OE_O,
	input  wire logic                 SDA_I,
	output logic                      SDA_O,
	output logic                      SDA_OE_O,
	// character streams
	input  wire logic                 TX_VALID_I,
	input  wire logic [7:0]           TX_DATA_I,
	output logic                      TX_READY_O,
	output logic                      RX_VALID_O,
	output logic [7:0]                RX_DATA_O,
	output logic                      RX_PAR_ERR_O,
	// status
	output logic                      PORT_ON_O,
	output logic                      DETECT_DONE_O,
	output logic [RATE_W-1:0]         RATE_O,
	output asp_pkg::asp_fmt_e         FMT_O,
	output logic                      FLOW_O,
	output logic                      DTR_ON_O
);
	import asp_pkg::*;

	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	typedef enum logic [2:0] {S_WAIT, S_MEAS, S_GAP, S_SAMP, S_DONE} asp_det_e;
	asp_det_e         det_q;
	logic             on_q, tx_pin_q;
	logic [RATE_W-1:0] rate_q;
	asp_fmt_e         fmt_q;
	logic             flow_q, xoff_q, detected_q;
	logic [DIV_W-1:0] div_q;
	logic [23:0]      meas_q;
	logic [9:0]       smp_q;
	logic [3:0]       sn_q;

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			on_q <= 1'b0;
		end else if (CE_I) begin
			on_q <= PIN_FUNC_SEL_I;
		end
	end

	// ----------------------------------------
	// one-shot autobaud and format detection
	// ----------------------------------------
	// measures the start-bit width of an 'A' (lsb 1) then samples the frame
	logic [RATE_W-1:0] best;
	always_comb begin
		best = RATE_DEFAULT;
		for (int i = 0; i < NUM_RATES; i++) begin
			if (meas_q >= 24'(asp_div(RATE_W'(i)) - (asp_div(RATE_W'(i)) >> 2))
				&& meas_q <= 24'(asp_div(RATE_W'(i)) + (asp_div(RATE_W'(i)) >> 2)))
				best = RATE_W'(i);
		end
	end

	logic     det_fmt_ok, low_ok;
	asp_fmt_e det_fmt;
	// smp_q holds bits 1..10 after start; 'A' is 0x41
	// 8N1, 8N2, 8O1 and 7E1 send alike bits for 'A' with idle behind: all settle on 8N1
	assign low_ok = (smp_q[6:0] == CHAR_AUTO[6:0]);
	always_comb begin
		det_fmt    = FMT_DEFAULT;
		det_fmt_ok = low_ok;
		if (smp_q[7] != CHAR_AUTO[7]) begin
			det_fmt    = ASP_FMT_7O1;
			det_fmt_ok = low_ok && smp_q[8] == LINE_STOP;
		end else if (smp_q[8] == LINE_STOP) begin
			det_fmt = ASP_FMT_8N1;
		end else begin
			det_fmt    = ASP_FMT_8E1;
			det_fmt_ok = low_ok && smp_q[9] == LINE_STOP;
		end
	end

	logic [DIV_W-1:0] cnt_q;
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			det_q      <= S_WAIT;
			rate_q     <= RATE_DEFAULT;
			fmt_q      <= FMT_DEFAULT;
			flow_q     <= FLOW_NONE;
			div_q      <= asp_div(RATE_DEFAULT);
			detected_q <= 1'b0;
			meas_q     <= '0;
			smp_q      <= '0;
			sn_q       <= '0;
			cnt_q      <= '0;
		end else if (CE_I) begin
			unique case (det_q)
				S_WAIT: begin
					if (!AUTO_EN_I) begin
						det_q <= S_DONE;
					end else if (on_q && SDA_I == LINE_START) begin
						det_q  <= S_MEAS;
						meas_q <= 24'h1;
					end
				end
				S_MEAS: begin
					if (SDA_I != LINE_START) begin
						rate_q <= best;
						div_q  <= asp_div(best);
						cnt_q  <= asp_div(best) >> 1;
						sn_q   <= '0;
						det_q  <= S_SAMP;
					end else if (meas_q != '1) begin
						meas_q <= meas_q + 24'h1;
					end
				end
				S_SAMP: begin
					if (cnt_q == '0) begin
						smp_q <= {SDA_I, smp_q[9:1]};
						sn_q  <= sn_q + 4'h1;
						cnt_q <= div_q - DIV_W'(1);
						if (sn_q == 4'h9) begin
							det_q <= S_GAP;
						end
					end else begin
						cnt_q <= cnt_q - DIV_W'(1);
					end
				end
				S_GAP: begin
					if (det_fmt_ok) begin
						fmt_q <= det_fmt;
					end
					detected_q <= 1'b1;
					det_q      <= S_DONE;
				end
				S_DONE: begin
					if (BIT_RATE_CMD_I && BIT_RATE_I < RATE_W'(NUM_RATES)) begin
						rate_q <= BIT_RATE_I;
						div_q  <= asp_div(BIT_RATE_I);
					end
					if (CHAR_FMT_CMD_I) begin
						fmt_q <= CHAR_FMT_I;
					end
					if (FLOW_CTRL_CMD_I) begin
						flow_q <= FLOW_CTRL_I;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	// only command and trace characters; no framing layer above bytes
	logic [3:0]       rn_q;
	logic [DIV_W-1:0] rc_q;
	logic [9:0]       rs_q;
	logic             rbusy_q;
	logic [3:0]       rlast;
	logic             rpar;
	assign rlast = asp_data_bits(fmt_q) + {3'h0, asp_has_par(fmt_q)};
	// 7-bit frames fill rs_q[9:2] only; rs_q[1] still holds a bit of the frame before
	assign rpar  = asp_has_par(fmt_q)
		&& (((asp_data_bits(fmt_q) == 4'h7) ? ^rs_q[9:2] : ^rs_q[9:1]) ^ asp_odd(fmt_q));

	logic [7:0] rxd;
	assign rxd = asp_has_par(fmt_q)
		? ((asp_data_bits(fmt_q) == 4'h7) ? {1'b0, rs_q[8:2]} : rs_q[8:1])
		: ((asp_data_bits(fmt_q) == 4'h7) ? {1'b0, rs_q[9:3]} : rs_q[9:2]);

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rbusy_q      <= 1'b0;
			rn_q         <= '0;
			rc_q         <= '0;
			rs_q         <= '0;
			RX_VALID_O   <= 1'b0;
			RX_DATA_O    <= '0;
			RX_PAR_ERR_O <= 1'b0;
			xoff_q       <= 1'b0;
		end else if (CE_I) begin
			RX_VALID_O <= 1'b0;
			if (!on_q || det_q != S_DONE) begin
				rbusy_q <= 1'b0;
			end else if (!rbusy_q) begin
				if (SDA_I == LINE_START) begin
					rbusy_q <= 1'b1;
					rc_q    <= (div_q >> 1) + div_q;
					rn_q    <= '0;
				end
			end else if (rc_q == '0) begin
				rn_q  <= rn_q + 4'h1;
				rc_q  <= div_q - DIV_W'(1);
				if (rn_q != rlast) begin
					rs_q <= {SDA_I, rs_q[9:1]};
				end else begin
					// stop bit centre: the frame is whole and the line high again,
					// so a low last bit cannot pass for the next start bit
					rbusy_q <= 1'b0;
					// with software flow control on, xon/xoff are consumed, not delivered
					if (flow_q == FLOW_SW && rxd == CHAR_XOFF) begin
						xoff_q <= 1'b1;
					end else if (flow_q == FLOW_SW && rxd == CHAR_XON) begin
						xoff_q <= 1'b0;
					end else begin
						RX_VALID_O   <= 1'b1;
						RX_DATA_O    <= rxd;
						RX_PAR_ERR_O <= rpar;
					end
				end
			end else begin
				rc_q <= rc_q - DIV_W'(1);
			end
		end
	end

	// ----------------------------------------
	// transmitter and pin drive
	// ----------------------------------------
	logic tx_rdy, txd, tx_en, tx_take;
	assign tx_en   = on_q && det_q == S_DONE && !xoff_q;
	// a byte moves only where valid meets the registered ready that the host sees
	assign tx_take = TX_VALID_I && TX_READY_O;
	asp_tx u_tx (
		.clk_i    (CLK_I),
		.arst_n_i (ARST_N_I),
		.ce_i     (CE_I),
		.div_i    (div_q),
		.fmt_i    (fmt_q),
		.en_i     (tx_en),
		.valid_i  (tx_take),
		.data_i   (TX_DATA_I),
		.ready_o  (tx_rdy),
		.txd_o    (txd)
	);

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SCL_O         <= LINE_IDLE;
			SCL_OE_O      <= 1'b0;
			SDA_O         <= LINE_IDLE;
			SDA_OE_O      <= 1'b0;
			TX_READY_O    <= 1'b0;
			PORT_ON_O     <= 1'b0;
			DETECT_DONE_O <= 1'b0;
			RATE_O        <= RATE_DEFAULT;
			FMT_O         <= FMT_DEFAULT;
			FLOW_O        <= FLOW_NONE;
			DTR_ON_O      <= 1'b0;
			tx_pin_q      <= 1'b0;
		end else if (CE_I) begin
			SCL_O         <= txd;
			SCL_OE_O      <= on_q;
			SDA_O         <= LINE_IDLE;
			SDA_OE_O      <= 1'b0;
			TX_READY_O    <= tx_rdy && !(TX_VALID_I && TX_READY_O);
			PORT_ON_O     <= on_q;
			DETECT_DONE_O <= detected_q;
			RATE_O        <= rate_q;
			FMT_O         <= fmt_q;
			FLOW_O        <= flow_q;
			DTR_ON_O      <= 1'b1;
			tx_pin_q      <= SCL_I;
		end
	end

endmodule : asp_top

/* File: testbench/asp_chk.sv */
`timescale 1ns/1ps
module asp_chk
	import asp_pkg::*;
(
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              ARST_N_I,
	// commands
	input  wire logic              PIN_FUNC_SEL_I,
	input  wire logic              BIT_RATE_CMD_I,
	input  wire logic              CHAR_FMT_CMD_I,
	input  wire logic              TX_VALID_I,
	// lines and status
	input  wire logic              SCL_O,
	input  wire logic              SCL_OE_O,
	input  wire logic              SDA_OE_O,
	input  wire logic              TX_READY_O,
	input  wire logic              RX_VALID_O,
	input  wire logic              PORT_ON_O,
	input  wire logic              DETECT_DONE_O,
	input  wire logic [RATE_W-1:0] RATE_O,
	input  asp_pkg::asp_fmt_e      FMT_O,
	input  wire logic              DTR_ON_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	AST_OFF_QUIET: assert property (!PORT_ON_O && !$past(PORT_ON_O) |-> !SCL_OE_O && SCL_O && !TX_READY_O)
		else $error("line or ready active with port off");
	AST_OFF_NO_RX: assert property (!PORT_ON_O && !$past(PORT_ON_O) |-> !RX_VALID_O)
		else $error("byte delivered with port off");
	AST_ON_FOLLOWS: assert property ($rose(PIN_FUNC_SEL_I) |-> ##[1:3] PORT_ON_O && SCL_OE_O)
		else $error("port not switched on");
	AST_SDA_INPUT: assert property (!SDA_OE_O)
		else $error("receive pin driven");
	AST_DTR_ON: assert property ($past(ARST_N_I) |-> DTR_ON_O)
		else $error("terminal ready not on");
	AST_RATE_HOLD: assert property (DETECT_DONE_O && $past(DETECT_DONE_O) && !$past(BIT_RATE_CMD_I)
		&& !$past(BIT_RATE_CMD_I, 2) |-> $stable(RATE_O))
		else $error("rate changed without command");
	AST_FMT_HOLD: assert property (DETECT_DONE_O && $past(DETECT_DONE_O) && !$past(CHAR_FMT_CMD_I)
		&& !$past(CHAR_FMT_CMD_I, 2) |-> $stable(FMT_O))
		else $error("format changed without command");
	AST_RATE_RANGE: assert property (RATE_O < 4'hc)
		else $error("rate index out of range");
	AST_TX_TAKE: assert property (TX_VALID_I && TX_READY_O |=> !TX_READY_O ##[1:2] !SCL_O)
		else $error("no start bit after take");
	AST_RX_PULSE: assert property (RX_VALID_O |=> !RX_VALID_O)
		else $error("receive strobe too long");
	AST_IDLE_HIGH: assert property ($rose(SCL_OE_O) |-> SCL_O)
		else $error("line not idle high when enabled");
endmodule : asp_chk

bind asp_top asp_chk i_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PIN_FUNC_SEL_I(PIN_FUNC_SEL_I),
	.BIT_RATE_CMD_I(BIT_RATE_CMD_I), .CHAR_FMT_CMD_I(CHAR_FMT_CMD_I), .TX_VALID_I(TX_VALID_I),
	.SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_OE_O(SDA_OE_O), .TX_READY_O(TX_READY_O),
	.RX_VALID_O(RX_VALID_O), .PORT_ON_O(PORT_ON_O), .DETECT_DONE_O(DETECT_DONE_O),
	.RATE_O(RATE_O), .FMT_O(FMT_O), .DTR_ON_O(DTR_ON_O));

/* File: testbench/asp_dte.sv */
`timescale 1ns/1ps
module asp_dte (
	// clock
	input  wire logic clk_i,
	// line
	input  wire logic txd_i,
	output logic      rxd_o
);
	initial rxd_o = 1'b1;

	task automatic send(input logic [7:0] b, input int dv, f, input bit bad);
		bit q[$];
		bit p;
		q = {1'b0};
		p = (f == 3 || f == 5) ^ bad;
		for (int i = 0; i < (f > 3 ? 7 : 8); i++) begin
			q.push_back(b[i]);
			p ^= b[i];
		end
		if (f > 1) q.push_back(p);
		q.push_back(1'b1);
		if (f == 0) q.push_back(1'b1);
		foreach (q[i]) begin
			rxd_o <= q[i];
			repeat (dv) @(posedge clk_i);
		end
	endtask : send

	task automatic recv(output logic [7:0] b, output logic p, s, input int dv, f);
		int t;
		b = 8'h00;
		t = 0;
		while (txd_i !== 1'b0 && t < 40 * dv) begin
			@(posedge clk_i);
			t++;
		end
		repeat (dv / 2) @(posedge clk_i);
		s = !txd_i;
		for (int i = 0; i < (f > 3 ? 7 : 8); i++) begin
			repeat (dv) @(posedge clk_i);
			b[i] = txd_i;
		end
		repeat (dv) @(posedge clk_i);
		p = txd_i;
		if (f > 1) repeat (dv) @(posedge clk_i);
		s &= txd_i;
		if (f == 0) repeat (dv) @(posedge clk_i);
		s &= txd_i;
	endtask : recv
endmodule : asp_dte

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	import asp_pkg::*;
	logic       clk, rst_n, sel, auto, rcmd, ccmd, fcmd, flw, tv, strict;
	logic [3:0] rate;
	asp_fmt_e   fmt;
	logic [7:0] td;
	logic       scl, scl_oe, sda_o, sda_oe, ready, rxv, perr, pon, done, flow_o, dtr, dte_rxd;
	logic [7:0] rxd;
	logic [3:0] rate_o;
	asp_fmt_e   fmt_o;
	wire        scl_line = scl_oe ? scl : 1'b1;
	wire        sda_line = sda_oe ? sda_o : dte_rxd;
	int         errors, num_checks, cyc, dv;
	logic [7:0] exq[$];
	logic       epq[$];

	asp_top i_asp_top (.CLK_I(clk), .ARST_N_I(rst_n), .CE_I(1'b1), .PIN_FUNC_SEL_I(sel),
		.AUTO_EN_I(auto), .BIT_RATE_CMD_I(rcmd), .BIT_RATE_I(rate), .CHAR_FMT_CMD_I(ccmd),
		.CHAR_FMT_I(fmt), .FLOW_CTRL_CMD_I(fcmd), .FLOW_CTRL_I(flw), .SCL_I(scl_line),
		.SCL_O(scl), .SCL_OE_O(scl_oe), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
		.TX_VALID_I(tv), .TX_DATA_I(td), .TX_READY_O(ready), .RX_VALID_O(rxv), .RX_DATA_O(rxd),
		.RX_PAR_ERR_O(perr), .PORT_ON_O(pon), .DETECT_DONE_O(done), .RATE_O(rate_o),
		.FMT_O(fmt_o), .FLOW_O(flow_o), .DTR_ON_O(dtr));
	asp_dte i_asp_dte (.clk_i(clk), .txd_i(scl_line), .rxd_o(dte_rxd));

	// --------
	// helpers
	// --------
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report();
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task automatic cmd(input int k, v);
		@(posedge clk);
		rcmd <= k == 0;
		ccmd <= k == 1;
		fcmd <= k == 2;
		rate <= 4'(v);
		fmt  <= asp_fmt_e'(v[2:0]);
		flw  <= v[0];
		@(posedge clk);
		{rcmd, ccmd, fcmd} <= 3'h0;
		repeat (3) @(posedge clk);
	endtask : cmd

	task automatic do_tx(input logic [7:0] b, input int f);
		int t;
		logic [7:0] g;
		logic p, s;
		t = 0;
		@(posedge clk);
		tv <= 1'b1;
		td <= b;
		do @(posedge clk); while (ready !== 1'b1 && ++t < 500);
		tv <= 1'b0;
		i_asp_dte.recv(g, p, s, dv, f);
		if (f > 3) b[7] = 1'b0;
		chk(g, b);
		if (f > 1) chk(p, ^b ^ (f == 3 || f == 5));
		chk(s, 1'b1);
	endtask : do_tx

	task automatic rx(input logic [7:0] b, input int f, input bit bad);
		exq.push_back(f > 3 ? {1'b0, b[6:0]} : b);
		epq.push_back(bad);
		i_asp_dte.send(b, dv, f, bad);
		repeat (dv) @(posedge clk);
	endtask : rx

	// --------
	// monitor
	// --------
	always @(posedge clk) begin
		if (rxv === 1'b1 && strict) begin
			if (exq.size() == 0) begin
				chk(rxv, 1'b0);
			end else begin
				chk(rxd, exq.pop_front());
				chk(perr, epq.pop_front());
			end
		end
		cyc++;
		if (cyc > 40000) begin
			errors++;
			final_report();
		end
	end

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// --------
	// sequence
	// --------
	initial begin
		int t;
		logic [7:0] b;
		{rst_n, sel, rcmd, ccmd, fcmd, flw, tv, strict} = 8'h00;
		auto = 1'b1;
		rate = 4'h0;
		fmt = ASP_FMT_8N1;
		td = 8'h00;
		dv = 217;
		void'($urandom(27));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(pon, 1'b0);
		chk(rate_o, 4'h4);
		chk(fmt_o, ASP_FMT_8N1);
		chk(flow_o, 1'b0);
		chk(dtr, 1'b1);
		i_asp_dte.send(CHAR_AUTO, dv, 1, 0);
		chk(done, 1'b0);
		sel <= 1'b1;
		repeat (10) @(posedge clk);
		i_asp_dte.send(CHAR_AUTO, dv, 1, 0);
		t = 0;
		while (done !== 1'b1 && t < 3000) begin
			@(posedge clk);
			t++;
		end
		chk(rate_o, 4'h7);
		chk(fmt_o, ASP_FMT_8N1);
		cmd(0, 12);
		chk(rate_o, 4'h7);
		strict = 1'b1;
		for (int f = 0; f < 6; f++) begin
			t = 8 + $urandom % 4;
			dv = CLK_HZ / BAUD_LIST[t];
			cmd(0, t);
			cmd(1, f);
			chk(rate_o, t);
			chk(fmt_o, f);
			b = 8'($urandom);
			do_tx(b, f);
			rx(b, f, 0);
			rx(~b, f, f > 1);
		end
		cmd(2, 1);
		chk(flow_o, 1'b1);
		i_asp_dte.send(CHAR_XOFF, dv, 5, 0);
		tv <= 1'b1;
		t = 0;
		repeat (300) @(posedge clk) t += !scl_line;
		tv <= 1'b0;
		chk(t, 0);
		i_asp_dte.send(CHAR_XON, dv, 5, 0);
		do_tx(8'h5a, 5);
		sel <= 1'b0;
		repeat (4) @(posedge clk);
		chk(pon, 1'b0);
		chk(scl_oe, 1'b0);
		chk(sda_oe, 1'b0);
		chk(sda_o, 1'b1);
		chk(exq.size(), 0);
		strict = 1'b0;
		auto <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(done, 1'b0);
		chk(rate_o, 4'h4);
		chk(fmt_o, ASP_FMT_8N1);
		cmd(0, 1);
		chk(rate_o, 4'h1);
		final_report();
	end
endmodule : tb
